/* encoder_turn_counter.sv */
// Single-turn and multiturn encoder counter with carry
`include "panel_pkg_defs.svh"
module encoder_turn_counter import panel_pkg::*; (
  input wire logic clk,
  input wire logic resetn,
  panel_enc_if.owner enc
);
  logic [22:0] single_turn;
  logic signed [15:0] multiturn;
  logic [22:0] next_single_turn;
  logic signed [15:0] next_multiturn;

  always_comb begin
    next_single_turn = single_turn;
    next_multiturn = multiturn;
    if (enc.step) begin
      if (enc.ccw) begin
        // Counter-clockwise counts up
        if (single_turn == `SINGLE_TURN_MAX) begin
          next_single_turn = 23'h000000; // RL9
          next_multiturn = multiturn + 16'sd1; // RL10 RL11
        end else begin
          next_single_turn = single_turn + 23'h000001; // RL9
        end
      end else begin
        if (single_turn == 23'h000000) begin
          next_single_turn = `SINGLE_TURN_MAX; // RL9
          // Natural two's complement wrap gives -32768 to 32767
          next_multiturn = multiturn - 16'sd1; // RL10 RL11
        end else begin
          next_single_turn = single_turn - 23'h000001; // RL9
        end
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      single_turn <= 23'h000000;
      multiturn <= 16'sh0000;
    end else begin
      single_turn <= next_single_turn;
      multiturn <= next_multiturn;
    end
  end

  assign enc.single_turn = single_turn;
  assign enc.multiturn = multiturn;
endmodule : encoder_turn_counter

/* front_panel_monitor_display.sv */
// Front panel monitor formatter with AXI4-Lite registers
// Notes on behaviour
// RL1: Showing the high half lights the two rightmost decimal points, the low half leaves them dark.
// RL2: A negative value lights the two leftmost decimal points, a positive one leaves them dark.
// RL3: Each left-arrow press toggles between low and high half of the wide value.
// RL4: In the I/O view an active signal lights the upper half of its digit, an inactive one the lower half.
// RL5: In the I/O view inputs light the decimal points, input one at the rightmost position.
// RL6: In the I/O view outputs keep decimal points dark, output one at the rightmost position.
// RL7: Not-running causes 1 to 6 are undervoltage, no servo-on, overtravel, alarm, relay, emergency stop.
// RL8: Not-running causes 7, 8, 9, 10, 12, 13 are position command low, torque limit, zero clamp, velocity, torque, velocity limit.
// RL9: Single-turn position spans 0 to 8388607, counter-clockwise positive, clockwise negative.
// RL10: Single-turn overflow increments and underflow decrements the multiturn count.
// RL11: Multiturn count is signed -32768 to 32767 and wraps both ways.
// RL12: The servo status item shows state machine state, fieldbus state, running mode and running condition.
// RL13: After power-on the shown item is the power-on selection, default 34.
// RL14: The power-on selection accepts 0 to 42 and takes effect only after a restart.
// RL15: Selection values 0 to 7, 9, 10, 12 and 13 name the listed monitor items.
// RL16: The low half shows the lower five decimal digits of the magnitude, the high half the rest.
//
// Our own choice: the AXI4-Lite register port.
`include "panel_pkg_defs.svh"
module front_panel_monitor_display import panel_pkg::*; #(
  parameter int IO_COUNT = 10
) (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic [15:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  input wire logic [15:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  input wire logic KEY_LEFT,
  input wire logic [IO_COUNT-1:0] DIGITAL_INPUT,
  input wire logic [IO_COUNT-1:0] DIGITAL_OUTPUT,
  input wire logic ENC_STEP,
  input wire logic ENC_CCW,
  input wire logic BUS_UNDERVOLT,
  input wire logic SERVO_ON_INPUT,
  input wire logic OVERTRAVEL_INPUT,
  input wire logic DRIVE_ALARM,
  input wire logic RELAY_OPEN,
  input wire logic ESTOP_INPUT,
  input wire logic POS_CMD_LOW,
  input wire logic TORQUE_LIMIT,
  input wire logic ZERO_CLAMP,
  input wire logic VEL_CMD_LOW,
  input wire logic TRQ_CMD_LOW,
  input wire logic VEL_LIMIT,
  input wire logic [3:0] STATE_MACHINE_STATE,
  input wire logic [3:0] FIELDBUS_STATE,
  input wire logic [3:0] RUN_MODE,
  input wire logic [3:0] RUN_CONDITION,
  input wire logic [31:0] WIDE_VALUE,
  output logic [5:0] SHOWN_ITEM,
  output logic HIGH_HALF,
  output logic [16:0] DIGITS_BCD,
  output logic [IO_COUNT-1:0] SEG_UPPER,
  output logic [IO_COUNT-1:0] SEG_LOWER,
  output logic [IO_COUNT-1:0] DP
);
  // ****************************************
  // Register state
  // ****************************************
  logic [15:0] power_on_sel;
  logic [5:0] view;
  logic high_half;
  logic io_out;
  logic key_prev;
  logic boot;
  logic [15:0] next_power_on_sel;
  logic [5:0] next_view;
  logic next_high_half;
  logic next_io_out;
  logic next_boot;
  logic [3:0] cause;
  logic [31:0] magnitude;
  logic negative;
  logic [16:0] digits;
  logic [16:0] next_digits;
  logic [IO_COUNT-1:0] seg_upper;
  logic [IO_COUNT-1:0] seg_lower;
  logic [IO_COUNT-1:0] dp;
  logic [IO_COUNT-1:0] next_seg_upper;
  logic [IO_COUNT-1:0] next_seg_lower;
  logic [IO_COUNT-1:0] next_dp;
  panel_enc_if enc ();

  encoder_turn_counter u_counter (
    .clk(CLK),
    .resetn(RESETN),
    .enc(enc)
  );
  assign enc.step = ENC_STEP;
  assign enc.ccw = ENC_CCW;

  // ****************************************
  // AXI4-Lite slave
  // ****************************************
  axi_state_e wstate, next_wstate;
  axi_state_e rstate, next_rstate;
  logic [31:0] rdata, next_rdata;
  logic [1:0] bresp, next_bresp, rresp, next_rresp;
  logic wr_fire;
  logic rd_fire;
  // Both address and data must be present; simple, one write at a time
  assign wr_fire = (wstate == AXI_IDLE) && AWVALID && WVALID;
  assign rd_fire = (rstate == AXI_IDLE) && ARVALID;
  assign AWREADY = wr_fire;
  assign WREADY = wr_fire;
  assign ARREADY = rd_fire;
  assign BVALID = (wstate == AXI_RESP);
  assign RVALID = (rstate == AXI_RESP);
  assign BRESP = bresp;
  assign RRESP = rresp;
  assign RDATA = rdata;

  function automatic logic [3:0] pick_cause(input logic [11:0] c);
    logic [3:0] r;
    r = CAUSE_NONE;
    // Lowest code wins when several causes stand
    if (c[0]) r = CAUSE_UNDERVOLT; // RL7
    else if (c[1]) r = CAUSE_NO_SERVO_ON; // RL7
    else if (c[2]) r = CAUSE_OVERTRAVEL; // RL7
    else if (c[3]) r = CAUSE_ALARM; // RL7
    else if (c[4]) r = CAUSE_RELAY; // RL7
    else if (c[5]) r = CAUSE_ESTOP; // RL7
    else if (c[6]) r = CAUSE_POS_CMD_LOW; // RL8
    else if (c[7]) r = CAUSE_TORQUE_LIMIT; // RL8
    else if (c[8]) r = CAUSE_ZERO_CLAMP; // RL8
    else if (c[9]) r = CAUSE_VEL_CMD_LOW; // RL8
    else if (c[10]) r = CAUSE_TRQ_CMD_LOW; // RL8
    else if (c[11]) r = CAUSE_VEL_LIMIT; // RL8
    return r;
  endfunction : pick_cause

  assign cause = pick_cause({VEL_LIMIT, TRQ_CMD_LOW, VEL_CMD_LOW, ZERO_CLAMP, TORQUE_LIMIT,
    POS_CMD_LOW, ESTOP_INPUT, RELAY_OPEN, DRIVE_ALARM, OVERTRAVEL_INPUT, !SERVO_ON_INPUT, BUS_UNDERVOLT});

  always_comb begin
    next_wstate = wstate;
    next_bresp = bresp;
    next_power_on_sel = power_on_sel;
    next_io_out = io_out;
    next_boot = 1'b0; // Restart request lives one cycle
    if (wr_fire) begin
      next_wstate = AXI_RESP;
      next_bresp = 2'h0;
      if (AWADDR == `REG_POWER_ON_SEL) begin
        // Out of range values are dropped and answered with SLVERR
        if (WDATA[15:0] <= `POWER_ON_SEL_MAX) begin
          if (WSTRB[0]) next_power_on_sel[7:0] = WDATA[7:0]; // RL14
          if (WSTRB[1]) next_power_on_sel[15:8] = WDATA[15:8]; // RL14
        end else begin
          next_bresp = 2'h2;
        end
      end else if (AWADDR == `REG_CONTROL) begin
        if (WSTRB[0]) begin
          next_io_out = WDATA[`CTRL_IO_OUT];
          next_boot = WDATA[`CTRL_RESTART];
        end
      end else begin
        next_bresp = 2'h2;
      end
    end else if (wstate == AXI_RESP && BREADY) begin
      next_wstate = AXI_IDLE;
    end
  end

  always_comb begin
    next_rstate = rstate;
    next_rdata = rdata;
    next_rresp = rresp;
    if (rd_fire) begin
      next_rstate = AXI_RESP;
      next_rresp = 2'h0;
      next_rdata = 32'h00000000;
      if (ARADDR == `REG_POWER_ON_SEL) begin
        next_rdata = {16'h0000, power_on_sel};
      end else if (ARADDR == `REG_CONTROL) begin
        next_rdata = {29'h00000000, io_out, 1'b0, 1'b0};
      end else if (ARADDR == `REG_DISPLAY) begin
        next_rdata = {24'h000000, 1'b0, high_half, view};
      end else if (ARADDR == `REG_STATUS) begin
        next_rdata = {31'h00000000, negative};
      end else if (ARADDR == `REG_IO_STATE) begin
        next_rdata = {12'h000, DIGITAL_OUTPUT, DIGITAL_INPUT};
      end else if (ARADDR == `REG_CAUSE) begin
        next_rdata = {28'h0000000, cause};
      end else if (ARADDR == `REG_SERVO_STATE) begin
        next_rdata = {16'h0000, RUN_CONDITION, RUN_MODE, FIELDBUS_STATE, STATE_MACHINE_STATE}; // RL12
      end else if (ARADDR == `REG_VALUE) begin
        next_rdata = {15'h0000, digits};
      end else if (ARADDR == `REG_ENCODER) begin
        next_rdata = {9'h000, enc.single_turn};
      end else if (ARADDR == `REG_MULTITURN) begin
        next_rdata = {{16{enc.multiturn[15]}}, enc.multiturn};
      end else begin
        next_rresp = 2'h2;
      end
    end else if (rstate == AXI_RESP && RREADY) begin
      next_rstate = AXI_IDLE;
    end
  end

  // ****************************************
  // View selection and half toggle
  // ****************************************
  always_comb begin
    next_view = view;
    next_high_half = high_half;
    if (boot) begin
      // Stored selection applies only at start-up or software restart
      next_view = power_on_sel[5:0]; // RL13 RL14 RL15
      // Boot flag is cleared by the write logic, its only driver
      next_high_half = 1'b0;
    end
    if (KEY_LEFT && !key_prev) begin
      next_high_half = !high_half; // RL3
    end
  end

  // ****************************************
  // Display formatting
  // ****************************************
  assign negative = WIDE_VALUE[31];
  assign magnitude = negative ? (32'h00000000 - WIDE_VALUE) : WIDE_VALUE;

  always_comb begin
    next_digits = 17'h00000;
    next_dp = '0;
    next_seg_upper = '0;
    next_seg_lower = '0;
    if (view == VIEW_IO_STATUS) begin
      // Bit 0 is the rightmost digit
      next_seg_upper = io_out ? DIGITAL_OUTPUT : DIGITAL_INPUT; // RL4 RL5 RL6
      next_seg_lower = io_out ? ~DIGITAL_OUTPUT : ~DIGITAL_INPUT; // RL4
      next_dp = io_out ? '0 : '1; // RL5 RL6
    end else if (view == VIEW_NOT_RUNNING) begin
      next_digits = {13'h0000, cause}; // RL7 RL8
    end else if (view == VIEW_SERVO_STATUS) begin
      next_digits = {1'b0, RUN_CONDITION, RUN_MODE, FIELDBUS_STATE, STATE_MACHINE_STATE}; // RL12
    end else begin
      // Divider is costly but runs at panel speed only
      if (high_half) begin
        next_digits = 17'(magnitude / `LOW_HALF_DIV); // RL16
      end else begin
        next_digits = 17'(magnitude % `LOW_HALF_DIV); // RL16
      end
      next_dp[`DP_HIGH_A] = high_half; // RL1
      next_dp[`DP_HIGH_B] = high_half; // RL1
      next_dp[`DP_NEG_A] = negative; // RL2
      next_dp[`DP_NEG_B] = negative; // RL2
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      wstate <= AXI_IDLE;
      rstate <= AXI_IDLE;
      bresp <= 2'h0;
      rresp <= 2'h0;
      rdata <= 32'h00000000;
      power_on_sel <= `POWER_ON_SEL_RESET;
      io_out <= 1'b0;
      boot <= 1'b1;
      view <= VIEW_SERVO_STATUS;
      high_half <= 1'b0;
      key_prev <= 1'b0;
      digits <= 17'h00000;
      seg_upper <= '0;
      seg_lower <= '0;
      dp <= '0;
    end else begin
      wstate <= next_wstate;
      rstate <= next_rstate;
      bresp <= next_bresp;
      rresp <= next_rresp;
      rdata <= next_rdata;
      power_on_sel <= next_power_on_sel;
      io_out <= next_io_out;
      boot <= next_boot;
      view <= next_view;
      high_half <= next_high_half;
      key_prev <= KEY_LEFT;
      digits <= next_digits;
      seg_upper <= next_seg_upper;
      seg_lower <= next_seg_lower;
      dp <= next_dp;
    end
  end

  assign SHOWN_ITEM = view;
  assign HIGH_HALF = high_half;
  assign DIGITS_BCD = digits;
  assign SEG_UPPER = seg_upper;
  assign SEG_LOWER = seg_lower;
  assign DP = dp;
endmodule : front_panel_monitor_display

/* front_panel_monitor_display_checker.sv */
// Port-level checks for the panel formatter
module front_panel_monitor_display_checker import panel_pkg::*; #(
  parameter int IO_COUNT = 10
) (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic AWVALID,
  input wire logic AWREADY,
  input wire logic WVALID,
  input wire logic WREADY,
  input wire logic BVALID,
  input wire logic ARVALID,
  input wire logic ARREADY,
  input wire logic RVALID,
  input wire logic KEY_LEFT,
  input wire logic [31:0] WIDE_VALUE,
  input wire logic [5:0] SHOWN_ITEM,
  input wire logic HIGH_HALF,
  input wire logic [IO_COUNT-1:0] DIGITAL_INPUT,
  input wire logic [IO_COUNT-1:0] DIGITAL_OUTPUT,
  input wire logic [IO_COUNT-1:0] SEG_UPPER,
  input wire logic [IO_COUNT-1:0] SEG_LOWER,
  input wire logic [IO_COUNT-1:0] DP
);
  // ****************************************
  // Helpers
  // ****************************************
  logic io;
  logic dev;
  logic neg;
  assign io = SHOWN_ITEM == VIEW_IO_STATUS;
  assign dev = SHOWN_ITEM == VIEW_DEVIATION;
  assign neg = WIDE_VALUE[31];
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);
  // ****************************************
  // Properties
  // ****************************************
  property p_boot_item;
    $rose(RESETN) |-> ##[0:2] SHOWN_ITEM == VIEW_SERVO_STATUS;
  endproperty
  a_boot_item: assert property (p_boot_item) else $error("item after reset wrong");
  property p_half_toggle;
    $rose(KEY_LEFT) |-> ##[1:3] $changed(HIGH_HALF);
  endproperty
  a_half_toggle: assert property (p_half_toggle) else $error("key did not toggle half");
  property p_dp_high;
    dev && $stable(SHOWN_ITEM) && $stable(HIGH_HALF) |=> DP[1:0] == {2{$past(HIGH_HALF)}};
  endproperty
  a_dp_high: assert property (p_dp_high) else $error("half marker wrong");
  property p_dp_neg;
    dev && $stable(WIDE_VALUE) && $stable(SHOWN_ITEM) |=> DP[4:3] == {2{$past(neg)}};
  endproperty
  a_dp_neg: assert property (p_dp_neg) else $error("sign marker wrong");
  property p_io_halves;
    io && $stable(SHOWN_ITEM) |=> SEG_LOWER == ~SEG_UPPER;
  endproperty
  a_io_halves: assert property (p_io_halves) else $error("io halves not opposite");
  property p_io_in;
    io && $stable(SHOWN_ITEM) && $stable(DIGITAL_INPUT) ##1 DP == '1 |-> SEG_UPPER == $past(DIGITAL_INPUT);
  endproperty
  a_io_in: assert property (p_io_in) else $error("input segments wrong");
  property p_io_out;
    io && $stable(SHOWN_ITEM) && $stable(DIGITAL_OUTPUT) ##1 DP == '0 |-> SEG_UPPER == $past(DIGITAL_OUTPUT);
  endproperty
  a_io_out: assert property (p_io_out) else $error("output segments wrong");
  property p_b_answer;
    AWVALID && AWREADY && WVALID && WREADY |=> BVALID ##1 !BVALID;
  endproperty
  a_b_answer: assert property (p_b_answer) else $error("write answer late");
  property p_r_answer;
    ARVALID && ARREADY |=> RVALID ##1 !RVALID;
  endproperty
  a_r_answer: assert property (p_r_answer) else $error("read answer late");
endmodule : front_panel_monitor_display_checker

bind front_panel_monitor_display front_panel_monitor_display_checker #(.IO_COUNT(IO_COUNT))
  u_front_panel_monitor_display_checker (.CLK(CLK), .RESETN(RESETN), .AWVALID(AWVALID), .AWREADY(AWREADY),
  .WVALID(WVALID), .WREADY(WREADY), .BVALID(BVALID), .ARVALID(ARVALID), .ARREADY(ARREADY), .RVALID(RVALID),
  .KEY_LEFT(KEY_LEFT), .WIDE_VALUE(WIDE_VALUE), .SHOWN_ITEM(SHOWN_ITEM), .HIGH_HALF(HIGH_HALF),
  .DIGITAL_INPUT(DIGITAL_INPUT), .DIGITAL_OUTPUT(DIGITAL_OUTPUT), .SEG_UPPER(SEG_UPPER),
  .SEG_LOWER(SEG_LOWER), .DP(DP));

/* panel_enc_if.sv */
// Encoder counter handshake between panel top and counter
interface panel_enc_if;
  logic step;
  logic ccw;
  logic [22:0] single_turn;
  logic signed [15:0] multiturn;
  modport owner (input step, input ccw, output single_turn, output multiturn);
  modport user (output step, output ccw, input single_turn, input multiturn);
endinterface : panel_enc_if

/* panel_keys_model.sv */
// Front panel key pressed by a person
module panel_keys_model (
  input wire logic clk,
  output logic key
);
  timeunit 1ns;
  timeprecision 1ns;
  initial key = 1'b0;
  // Held several clocks, as a finger is far slower than the clock
  task automatic press();
    @(posedge clk);
    key <= 1'b1;
    repeat (3) @(posedge clk);
    key <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : press
endmodule : panel_keys_model

/* panel_pkg.sv */
// Types shared by the panel modules
package panel_pkg;
  typedef enum logic [1:0] {
    AXI_IDLE = 2'b00,
    AXI_RESP = 2'b01
  } axi_state_e;
  typedef enum logic [3:0] {
    CAUSE_NONE = 4'h0,
    CAUSE_UNDERVOLT = 4'h1,
    CAUSE_NO_SERVO_ON = 4'h2,
    CAUSE_OVERTRAVEL = 4'h3,
    CAUSE_ALARM = 4'h4,
    CAUSE_RELAY = 4'h5,
    CAUSE_ESTOP = 4'h6,
    CAUSE_POS_CMD_LOW = 4'h7,
    CAUSE_TORQUE_LIMIT = 4'h8,
    CAUSE_ZERO_CLAMP = 4'h9,
    CAUSE_VEL_CMD_LOW = 4'ha,
    CAUSE_TRQ_CMD_LOW = 4'hc,
    CAUSE_VEL_LIMIT = 4'hd
  } cause_e;
  typedef enum logic [5:0] {
    VIEW_DEVIATION = 6'd0,
    VIEW_IO_STATUS = 6'd10,
    VIEW_NOT_RUNNING = 6'd17,
    VIEW_SINGLE_TURN = 6'd21,
    VIEW_MULTITURN = 6'd22,
    VIEW_SERVO_STATUS = 6'd34
  } view_e;
endpackage : panel_pkg

/* panel_pkg_defs.svh */
// Register offsets, field layouts, reset values and display constants
`ifndef PANEL_PKG_DEFS_SVH
`define PANEL_PKG_DEFS_SVH
// ****************************************
// Register map (byte addresses)
// ****************************************
`define REG_POWER_ON_SEL 16'h2528
`define REG_CONTROL 16'h0000
`define REG_DISPLAY 16'h0004
`define REG_STATUS 16'h0008
`define REG_IO_STATE 16'h000c
`define REG_CAUSE 16'h0010
`define REG_SERVO_STATE 16'h0014
`define REG_VALUE 16'h0018
`define REG_ENCODER 16'h001c
`define REG_MULTITURN 16'h0020
// ****************************************
// Reset values and limits
// ****************************************
`define POWER_ON_SEL_RESET 16'h0022
`define POWER_ON_SEL_MAX 16'h002a
`define SINGLE_TURN_MAX 23'h7fffff
`define LOW_HALF_DIV 32'd100000
// ****************************************
// Field positions
// ****************************************
`define CTRL_KEY_LEFT 0
`define CTRL_RESTART 1
`define CTRL_IO_OUT 2
`define CTRL_VIEW_LSB 8
`define ENC_DIR_CCW 0
`define ENC_STEP 1
`define DP_HIGH_A 0
`define DP_HIGH_B 1
`define DP_NEG_A 3
`define DP_NEG_B 4
`endif

/* test_front_panel_monitor_display.sv */
// Register and panel tests for the monitor formatter
`include "panel_pkg_defs.svh"
module test_front_panel_monitor_display;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, awready, wready, bvalid, arready, rvalid, key, high_half;
  logic resetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, bready = 1'b1, rready = 1'b1;
  logic enc_step = 1'b0, enc_ccw = 1'b0;
  logic [15:0] awaddr = 16'h0, araddr = 16'h0;
  logic [31:0] wdata = 32'h0, wide = 32'h0, rdata, d;
  logic [1:0] bresp, rresp, r;
  logic [15:0] sv = 16'h4321;
  logic [9:0] di = 10'h0, dout = 10'h0, seg_up, seg_lo, dp;
  logic [11:0] cz = 12'h0;
  logic [16:0] digits;
  logic [5:0] shown;
  int fail_count = 0;
  int tests_run = 0;
  int codes[12] = '{1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 12, 13};
  front_panel_monitor_display u_front_panel_monitor_display (.CLK(clk), .RESETN(resetn), .AWADDR(awaddr),
    .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata), .WSTRB(4'hf), .WVALID(wvalid), .WREADY(wready),
    .BRESP(bresp), .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready),
    .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready), .KEY_LEFT(key), .DIGITAL_INPUT(di),
    .DIGITAL_OUTPUT(dout), .ENC_STEP(enc_step), .ENC_CCW(enc_ccw), .BUS_UNDERVOLT(cz[0]),
    .SERVO_ON_INPUT(~cz[1]), .OVERTRAVEL_INPUT(cz[2]), .DRIVE_ALARM(cz[3]), .RELAY_OPEN(cz[4]),
    .ESTOP_INPUT(cz[5]), .POS_CMD_LOW(cz[6]), .TORQUE_LIMIT(cz[7]), .ZERO_CLAMP(cz[8]), .VEL_CMD_LOW(cz[9]),
    .TRQ_CMD_LOW(cz[10]), .VEL_LIMIT(cz[11]), .STATE_MACHINE_STATE(sv[3:0]), .FIELDBUS_STATE(sv[7:4]),
    .RUN_MODE(sv[11:8]), .RUN_CONDITION(sv[15:12]), .WIDE_VALUE(wide), .SHOWN_ITEM(shown), .HIGH_HALF(high_half),
    .DIGITS_BCD(digits),
    .SEG_UPPER(seg_up), .SEG_LOWER(seg_lo), .DP(dp));
  panel_keys_model u_panel_keys_model (.clk(clk), .key(key));
  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Ready lines rise only while both valids are up, so each valid is held until its ready is seen
  task automatic wr(input logic [15:0] a, input logic [31:0] v);
    logic aw;
    logic w;
    aw = 1'b1;
    w = 1'b1;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (aw || w) begin
      @(posedge clk);
      if (aw && awready) begin
        aw = 1'b0;
        awvalid <= 1'b0;
      end
      if (w && wready) begin
        w = 1'b0;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (bvalid !== 1'b1);
    r = bresp;
  endtask : wr
  task automatic rd(input logic [15:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
  endtask : rd
  task automatic wchk(input logic [15:0] a, input logic [31:0] v, input logic [1:0] e);
    wr(a, v);
    chk(r, e);
  endtask : wchk
  task automatic rchk(input logic [15:0] a, input logic [31:0] e, input logic [1:0] er);
    rd(a);
    if (er == 2'b00) chk(d, e);
    chk(r, er);
  endtask : rchk
  // View is only reachable through the stored selection and a restart
  task automatic show(input logic [5:0] v);
    wchk(`REG_POWER_ON_SEL, {26'h0000000, v}, 2'b00);
    wchk(`REG_CONTROL, 32'h00000002, 2'b00);
  endtask : show
  task automatic step(input logic dir);
    enc_ccw <= dir;
    enc_step <= 1'b1;
    @(posedge clk);
    enc_step <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : step
  task automatic settle();
    repeat (3) @(posedge clk);
  endtask : settle
  task automatic finish_test();
    if (fail_count == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : finish_test
  // ****************************************
  // Clock, watchdog and sequence
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    #2000000;
    fail_count++;
    finish_test();
  end
  initial begin
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    settle();
    chk(shown, 34);
    rchk(`REG_POWER_ON_SEL, 32'h22, 2'b00);
    wchk(`REG_POWER_ON_SEL, 43, 2'b10);
    rchk(`REG_POWER_ON_SEL, 32'h22, 2'b00);
    wchk(`REG_POWER_ON_SEL, 42, 2'b00);
    wchk(`REG_POWER_ON_SEL, 10, 2'b00);
    settle();
    chk(shown, 34);
    wchk(`REG_CONTROL, 2, 2'b00);
    wchk(`REG_CONTROL, 0, 2'b00);
    chk(shown, 10);
    rchk(16'h0100, 0, 2'b10);
    di <= 10'h281;
    dout <= 10'h001;
    settle();
    chk(seg_up, 10'h281);
    chk(seg_lo, 10'h17e);
    chk(dp, 10'h3ff);
    wchk(`REG_CONTROL, 4, 2'b00);
    settle();
    chk(seg_up, 10'h001);
    chk(seg_lo, 10'h3fe);
    chk(dp, 10'h000);
    wchk(`REG_CONTROL, 0, 2'b00);
    wide <= -260885;
    show(6'd0);
    settle();
    chk(digits, 60885);
    chk(dp[4:0], 5'h18);
    u_panel_keys_model.press();
    chk(high_half, 1'b1);
    chk(digits, 2);
    chk(dp[4:0], 5'h1b);
    rd(`REG_STATUS);
    chk(d[0], 1'b1);
    wide <= 260885;
    settle();
    chk(dp[4:0], 5'h03);
    u_panel_keys_model.press();
    chk(high_half, 1'b0);
    chk(dp[4:0], 5'h00);
    show(6'd17);
    // One cause at a time, then all at once for the priority order
    for (int i = 0; i < 12; i++) begin
      cz <= 12'(1 << i);
      settle();
      rchk(`REG_CAUSE, codes[i], 2'b00);
      chk(digits, codes[i]);
    end
    cz <= 12'hfff;
    settle();
    rchk(`REG_CAUSE, 1, 2'b00);
    cz <= 12'h000;
    step(1'b0);
    rchk(`REG_ENCODER, 32'h7fffff, 2'b00);
    rchk(`REG_MULTITURN, 32'hffffffff, 2'b00);
    step(1'b1);
    rchk(`REG_ENCODER, 0, 2'b00);
    rchk(`REG_MULTITURN, 0, 2'b00);
    step(1'b1);
    rchk(`REG_ENCODER, 1, 2'b00);
    rchk(`REG_SERVO_STATE, 32'h00004321, 2'b00);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    settle();
    chk(shown, 34);
    chk(digits, 32'h00004321);
    finish_test();
  end
endmodule : test_front_panel_monitor_display
